// ===== rtl/lic_pkg.sv
// package for the lcd command interpreter: command codes, field layout,
// reset values and the bus carrier type.
// assumes a single core clock domain and a synchronous active-low reset.
package lic_pkg;

  // ****************************************************************
  // command codes and decode masks
  // ****************************************************************
  localparam logic [7:0] CMD_NLINE_ENTRY   = 8'h85; // starts the line-count pair
  localparam logic [7:0] CMD_NLINE_RELEASE = 8'h84; // back to frame inversion
  localparam logic [7:0] CMD_PUMP_ENTRY    = 8'he6; // starts the pump divider pair
  localparam logic [7:0] PAT_DISPLAY       = 8'hae;
  localparam logic [7:0] MSK_ONE_BIT       = 8'hfe; // pattern with a free bit 0
  localparam logic [7:0] PAT_START_LINE    = 8'h40;
  localparam logic [7:0] MSK_START_LINE    = 8'hc0;
  localparam logic [7:0] PAT_PAGE          = 8'hb0;
  localparam logic [7:0] PAT_COL_HIGH      = 8'h10;
  localparam logic [7:0] PAT_COL_LOW       = 8'h00;
  localparam logic [7:0] MSK_NIBBLE        = 8'hf0; // pattern with a free low nibble
  localparam logic [7:0] PAT_SEG_DIR       = 8'ha0;
  localparam logic [7:0] PAT_REVERSE       = 8'ha6;
  localparam logic [7:0] PAT_PARTIAL       = 8'h82;
  localparam logic [7:0] PAT_DUTY          = 8'h30;
  localparam logic [7:0] MSK_DUTY          = 8'hf8;

  // ****************************************************************
  // address space and field limits
  // ****************************************************************
  localparam logic [3:0]  PAGE_LAST  = 4'h8;
  localparam logic [7:0]  COL_LAST   = 8'h83;  // column 131
  localparam int unsigned RAM_COLS   = 132;
  localparam int unsigned RAM_DEPTH  = 1188;   // 9 pages of 132 columns
  localparam logic [2:0]  DUTY_1_9   = 3'h0;
  localparam logic [2:0]  DUTY_1_17  = 3'h1;
  localparam logic [2:0]  DUTY_LAST  = 3'h4;

  // ****************************************************************
  // reset values and status layout
  // ****************************************************************
  localparam logic [2:0] DUTY_RESET     = 3'h4;  // full duty
  localparam logic [3:0] PUMP_DIV_RESET = 4'h3;
  localparam logic [4:0] NLINE_RESET    = 5'h00;
  localparam logic [3:0] STATUS_LOW     = 4'h0;
  localparam int unsigned STAT_SEG_BIT  = 6;
  localparam int unsigned STAT_OFF_BIT  = 5;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic       cmd_data_select;
    logic [7:0] data;
  } lic_bus_s;

  typedef enum logic [1:0] {
    PAIR_IDLE  = 2'b00,
    PAIR_NLINE = 2'b01,
    PAIR_DIV   = 2'b10
  } lic_pair_e;

endpackage : lic_pkg

// ===== rtl/lic_pin_filter.sv
// three-stage pin synchroniser with agreement filter.
// assumes inputs are asynchronous pins; output changes once stages two and three agree.
`timescale 1ns/100ps
module lic_pin_filter #(
  parameter int unsigned        WIDTH = 1,
  parameter logic [WIDTH-1:0]   INIT  = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // a bit moves only when the two settled stages agree on it
  assign next_level = (stage2 & stage3) | (level_out & (stage2 | stage3));

  // ****************************************************************
  // synchroniser chain
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stage1    <= INIT;
      stage2    <= INIT;
      stage3    <= INIT;
      level_out <= INIT;
    end else begin
      stage1    <= pin_in;
      stage2    <= stage1;
      stage3    <= stage2;
      level_out <= next_level;
    end
  end

endmodule : lic_pin_filter

// ===== rtl/lic_pump_div.sv
// charge-pump clock divider driven by oscillator ticks.
// assumes osc_tick_in is a one-cycle pulse per oscillator period.
`timescale 1ns/100ps
module lic_pump_div
  import lic_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       osc_tick_in,
  input  wire logic [3:0] div_code_in,
  output logic            pump_tick_out
);

  logic [4:0] tick_cnt;
  logic [4:0] period_last;
  logic       wrap;

  // code n gives one pump tick per 2n oscillator ticks, code 0 passes every tick
  assign period_last = (div_code_in == 4'h0) ? 5'h00 : 5'({div_code_in, 1'b0} - 5'h01);
  assign wrap        = osc_tick_in && (tick_cnt >= period_last);

  // ****************************************************************
  // divider counter
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tick_cnt      <= 5'h00;
      pump_tick_out <= 1'b0;
    end else begin
      pump_tick_out <= wrap;
      if (wrap) begin
        tick_cnt <= 5'h00;
      end else if (osc_tick_in) begin
        tick_cnt <= 5'(tick_cnt + 5'h01);
      end
    end
  end

endmodule : lic_pump_div

// ===== rtl/lic_cmd_top.sv
// command interpreter of a dot-matrix lcd controller: host bus, paired
// commands, display ram, line inversion polarity and pump clock.
// assumes host strobes and data arrive on asynchronous pins and that the
// oscillator, line and frame ticks are single-cycle pulses of the core clock.
`timescale 1ns/100ps
module lic_cmd_top
  import lic_pkg::*;
(
  input  wire logic       CORE_CLK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       CMD_DATA_SELECT_IN,
  input  wire logic       WR_N_IN,
  input  wire logic       RD_N_IN,
  input  wire logic [7:0] DATA_IN,
  input  wire logic       OSC_TICK_IN,
  input  wire logic       LINE_TICK_IN,
  input  wire logic       FRAME_START_IN,
  output logic      [7:0] DATA_OUT,
  output logic            DATA_OE_OUT,
  output logic            DISPLAY_ON_OUT,
  output logic      [5:0] START_LINE_OUT,
  output logic      [3:0] PAGE_OUT,
  output logic      [7:0] COLUMN_OUT,
  output logic            SEG_MIRROR_OUT,
  output logic            REVERSE_OUT,
  output logic            PARTIAL_OUT,
  output logic      [2:0] DUTY_OUT,
  output logic            NLINE_ACTIVE_OUT,
  output logic      [4:0] NLINE_COUNT_OUT,
  output logic      [3:0] PUMP_DIV_OUT,
  output logic            PUMP_TICK_OUT,
  output logic            POLARITY_OUT
);

  // ****************************************************************
  // helper functions
  // ****************************************************************
  function automatic logic cmd_match(input logic [7:0] code, input logic [7:0] pattern,
                                     input logic [7:0] mask);
    cmd_match = ((code ^ pattern) & mask) == 8'h00;
  endfunction : cmd_match

  function automatic logic [10:0] ram_index(input logic [3:0] page, input logic [7:0] col);
    ram_index = 11'(page * RAM_COLS) + 11'(col);
  endfunction : ram_index

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [1:0]  strobe_lvl;
  lic_bus_s    bus_raw;
  lic_bus_s    bus_lvl;
  lic_bus_s    bus_hold;
  logic        wr_prev;
  logic        rd_prev;
  logic        wr_done;
  logic        rd_start;
  logic        cmd_wr;
  logic        data_wr;
  logic [7:0]  cmd;
  lic_pair_e   pair_state;
  lic_pair_e   next_pair_state;
  logic [7:0]  ram [RAM_DEPTH];
  logic        nline_on;
  logic        nline_eff;
  logic        duty_cancel;
  logic [4:0]  line_cnt;
  logic        group_end;
  logic        addr_ok;
  logic [10:0] addr_idx;
  logic [7:0]  col_next;
  logic [7:0]  status_byte;
  logic        idle_cmd;
  logic        dec_display;
  logic        dec_start;
  logic        dec_page;
  logic        dec_col_high;
  logic        dec_col_low;
  logic        dec_seg;
  logic        dec_reverse;
  logic        dec_partial;
  logic        dec_duty;
  logic        dec_nline;
  logic        dec_release;
  logic        dec_pump;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  assign bus_raw.cmd_data_select = CMD_DATA_SELECT_IN;
  assign bus_raw.data            = DATA_IN;

  lic_pin_filter #(
    .WIDTH (2),
    .INIT  (2'b11)
  ) u_strobe_filter (
    .clk_in    (CORE_CLK_IN),
    .rst_n_in  (RST_N_IN),
    .pin_in    ({WR_N_IN, RD_N_IN}),
    .level_out (strobe_lvl)
  );

  lic_pin_filter #(
    .WIDTH (9),
    .INIT  (9'h000)
  ) u_bus_filter (
    .clk_in    (CORE_CLK_IN),
    .rst_n_in  (RST_N_IN),
    .pin_in    (bus_raw),
    .level_out (bus_lvl)
  );

  // ****************************************************************
  // strobe edges and bus capture
  // ****************************************************************
  // a write is taken when the filtered write strobe returns high
  assign wr_done  = !wr_prev && strobe_lvl[1];
  assign rd_start = rd_prev && !strobe_lvl[0];
  assign cmd      = bus_hold.data;
  assign cmd_wr   = wr_done && !bus_hold.cmd_data_select;
  assign data_wr  = wr_done && bus_hold.cmd_data_select;

  // bus is held from the last low-strobe cycle so late data changes do no harm
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      wr_prev  <= 1'b1;
      rd_prev  <= 1'b1;
      bus_hold <= '0;
    end else begin
      wr_prev <= strobe_lvl[1];
      rd_prev <= strobe_lvl[0];
      if (!strobe_lvl[1]) begin
        bus_hold <= bus_lvl;
      end
    end
  end

  // ****************************************************************
  // command decode, only outside a pair
  // ****************************************************************
  assign idle_cmd     = cmd_wr && (pair_state == PAIR_IDLE);
  assign dec_display  = idle_cmd && cmd_match(cmd, PAT_DISPLAY, MSK_ONE_BIT);
  assign dec_start    = idle_cmd && cmd_match(cmd, PAT_START_LINE, MSK_START_LINE);
  assign dec_page     = idle_cmd && cmd_match(cmd, PAT_PAGE, MSK_NIBBLE)
                        && (cmd[3:0] <= PAGE_LAST);
  assign dec_col_high = idle_cmd && cmd_match(cmd, PAT_COL_HIGH, MSK_NIBBLE);
  assign dec_col_low  = idle_cmd && cmd_match(cmd, PAT_COL_LOW, MSK_NIBBLE);
  assign dec_seg      = idle_cmd && cmd_match(cmd, PAT_SEG_DIR, MSK_ONE_BIT);
  assign dec_reverse  = idle_cmd && cmd_match(cmd, PAT_REVERSE, MSK_ONE_BIT);
  assign dec_partial  = idle_cmd && cmd_match(cmd, PAT_PARTIAL, MSK_ONE_BIT);
  assign dec_duty     = idle_cmd && cmd_match(cmd, PAT_DUTY, MSK_DUTY)
                        && (cmd[2:0] <= DUTY_LAST);
  assign dec_nline    = idle_cmd && (cmd == CMD_NLINE_ENTRY);
  assign dec_release  = idle_cmd && (cmd == CMD_NLINE_RELEASE);
  assign dec_pump     = idle_cmd && (cmd == CMD_PUMP_ENTRY);

  // ****************************************************************
  // paired command sequencer
  // ****************************************************************
  always_comb begin
    next_pair_state = pair_state;
    case (pair_state)
      PAIR_IDLE: begin
        if (dec_nline) begin
          next_pair_state = PAIR_NLINE;
        end else if (dec_pump) begin
          next_pair_state = PAIR_DIV;
        end
      end
      PAIR_NLINE: begin
        if (cmd_wr) begin
          next_pair_state = PAIR_IDLE;
        end
      end
      PAIR_DIV: begin
        if (cmd_wr) begin
          next_pair_state = PAIR_IDLE;
        end
      end
      default: begin
        next_pair_state = PAIR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      pair_state <= PAIR_IDLE;
    end else begin
      pair_state <= next_pair_state;
    end
  end

  // ****************************************************************
  // line inversion and pump divider settings
  // ****************************************************************
  // short duties in partial mode force frame inversion and clear the stored line inversion
  assign duty_cancel = PARTIAL_OUT && ((DUTY_OUT == DUTY_1_9) || (DUTY_OUT == DUTY_1_17));
  assign nline_eff   = nline_on && !duty_cancel;

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      nline_on        <= 1'b0;
      NLINE_COUNT_OUT <= NLINE_RESET;
      PUMP_DIV_OUT    <= PUMP_DIV_RESET;
    end else begin
      if (cmd_wr && (pair_state == PAIR_NLINE)) begin
        NLINE_COUNT_OUT <= cmd[4:0];
        nline_on        <= 1'b1;
      end else if (dec_release || duty_cancel) begin
        nline_on <= 1'b0;
      end
      if (cmd_wr && (pair_state == PAIR_DIV)) begin
        PUMP_DIV_OUT <= cmd[3:0];
      end
    end
  end

  assign NLINE_ACTIVE_OUT = nline_eff;

  lic_pump_div u_pump_div (
    .clk_in        (CORE_CLK_IN),
    .rst_n_in      (RST_N_IN),
    .osc_tick_in   (OSC_TICK_IN),
    .div_code_in   (PUMP_DIV_OUT),
    .pump_tick_out (PUMP_TICK_OUT)
  );

  // ****************************************************************
  // drive polarity
  // ****************************************************************
  assign group_end = nline_eff && LINE_TICK_IN && (line_cnt == NLINE_COUNT_OUT);

  // polarity flips every frame, and also after each group of lines when enabled
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      line_cnt     <= 5'h00;
      POLARITY_OUT <= 1'b0;
    end else if (FRAME_START_IN) begin
      line_cnt     <= 5'h00;
      POLARITY_OUT <= !POLARITY_OUT;
    end else if (group_end) begin
      line_cnt     <= 5'h00;
      POLARITY_OUT <= !POLARITY_OUT;
    end else if (nline_eff && LINE_TICK_IN) begin
      line_cnt <= 5'(line_cnt + 5'h01);
    end
  end

  // ****************************************************************
  // display settings
  // ****************************************************************
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      DISPLAY_ON_OUT <= 1'b0;
      START_LINE_OUT <= 6'h00;
      SEG_MIRROR_OUT <= 1'b0;
      REVERSE_OUT    <= 1'b0;
      PARTIAL_OUT    <= 1'b0;
      DUTY_OUT       <= DUTY_RESET;
    end else begin
      if (dec_display) begin
        DISPLAY_ON_OUT <= cmd[0];
      end
      if (dec_start) begin
        START_LINE_OUT <= cmd[5:0];
      end
      if (dec_seg) begin
        SEG_MIRROR_OUT <= cmd[0];
      end
      if (dec_reverse) begin
        REVERSE_OUT <= cmd[0];
      end
      if (dec_partial) begin
        PARTIAL_OUT <= cmd[0];
      end
      if (dec_duty) begin
        DUTY_OUT <= cmd[2:0];
      end
    end
  end

  // ****************************************************************
  // ram address pointers
  // ****************************************************************
  assign addr_ok  = (PAGE_OUT <= PAGE_LAST) && (COLUMN_OUT <= COL_LAST);
  assign addr_idx = ram_index(PAGE_OUT, COLUMN_OUT);
  assign col_next = (COLUMN_OUT < COL_LAST) ? 8'(COLUMN_OUT + 8'h01) : COLUMN_OUT;

  // column steps after every data access and stops at the last column
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      PAGE_OUT   <= 4'h0;
      COLUMN_OUT <= 8'h00;
    end else begin
      if (dec_page) begin
        PAGE_OUT <= cmd[3:0];
      end
      if (dec_col_high) begin
        COLUMN_OUT <= {cmd[3:0], COLUMN_OUT[3:0]};
      end else if (dec_col_low) begin
        COLUMN_OUT <= {COLUMN_OUT[7:4], cmd[3:0]};
      end else if (data_wr || (rd_start && bus_lvl.cmd_data_select)) begin
        COLUMN_OUT <= col_next;
      end
    end
  end

  // ****************************************************************
  // display ram
  // ****************************************************************
  always_ff @(posedge CORE_CLK_IN) begin
    if (data_wr && addr_ok) begin
      ram[addr_idx] <= cmd;
    end
  end

  // ****************************************************************
  // host read port
  // ****************************************************************
  assign status_byte = {1'b0, SEG_MIRROR_OUT, !DISPLAY_ON_OUT, 1'b0, STATUS_LOW};

  // data is latched at the start of the read and driven until the strobe rises
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      DATA_OUT    <= 8'h00;
      DATA_OE_OUT <= 1'b0;
    end else begin
      if (rd_start) begin
        DATA_OE_OUT <= 1'b1;
        if (!bus_lvl.cmd_data_select) begin
          DATA_OUT <= status_byte;
        end else if (addr_ok) begin
          DATA_OUT <= ram[addr_idx];
        end else begin
          DATA_OUT <= 8'h00;
        end
      end else if (strobe_lvl[0]) begin
        DATA_OE_OUT <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_nline_entry;
    dec_nline && !nline_on;
  endsequence

  sequence s_pair_second;
    cmd_wr && (pair_state == PAIR_NLINE);
  endsequence

  AST_PAIR_BLOCKS_DISPLAY: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (pair_state != PAIR_IDLE) && cmd_wr |=> $stable(DISPLAY_ON_OUT) && $stable(START_LINE_OUT))
    else $error("command acted on inside a pair");

  AST_NLINE_LOAD: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    s_pair_second |=> (NLINE_COUNT_OUT == $past(cmd[4:0])) && (pair_state == PAIR_IDLE))
    else $error("line count not loaded from low five bits");

  AST_GROUP_FLIP: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    nline_eff && LINE_TICK_IN && !FRAME_START_IN && (line_cnt == NLINE_COUNT_OUT)
    |=> (line_cnt == 5'h00) && (POLARITY_OUT != $past(POLARITY_OUT)))
    else $error("polarity group length wrong");

  AST_ENTRY_NO_EFFECT: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    s_nline_entry |=> !nline_on ##1 (!nline_on || $past(cmd_wr)))
    else $error("line inversion began on entry byte");

  AST_DUTY_CANCEL: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    duty_cancel && !FRAME_START_IN |-> !NLINE_ACTIVE_OUT ##1 $stable(POLARITY_OUT))
    else $error("line inversion active at short duty");

  AST_RELEASE: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    dec_release |=> !NLINE_ACTIVE_OUT)
    else $error("release left line inversion on");

  AST_DIV_LOAD: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    cmd_wr && (pair_state == PAIR_DIV) |=> (PUMP_DIV_OUT == $past(cmd[3:0]))
    && $stable(DISPLAY_ON_OUT))
    else $error("division byte not taken as pair second byte");

  AST_DIV_HOLD: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    !(cmd_wr && (pair_state == PAIR_DIV)) |=> $stable(PUMP_DIV_OUT))
    else $error("division register changed without its second byte");

  AST_DISPLAY_BIT: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    dec_display |=> (DISPLAY_ON_OUT == $past(cmd[0])))
    else $error("display on bit not taken from bit 0");

  AST_STATUS_LOW: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    rd_start && !bus_lvl.cmd_data_select |=> DATA_OE_OUT && (DATA_OUT[3:0] == 4'h0))
    else $error("status read low nibble not zero");

endmodule : lic_cmd_top

// ===== bench/lic_host_model.sv
// host microprocessor model driving the parallel bus pins of the block.
// assumes the block filters every pin through four flops of the core clock.
`timescale 1ns/100ps
module lic_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rd_data_in,
  input  wire logic       oe_in,
  output logic            sel_out,
  output logic            wr_n_out,
  output logic            rd_n_out,
  output logic      [7:0] data_out
);
  // idle bus at time zero
  initial begin
    sel_out = 1'b0;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    data_out = 8'h00;
  end
  task automatic ticks(input int k);
    repeat (k) @(negedge clk_in);
  endtask : ticks
  // one write strobe; bus set up early, held past the rising strobe
  task automatic wr(input logic sel, input logic [7:0] d);
    sel_out = sel;
    data_out = d;
    ticks(5);
    wr_n_out = 1'b0;
    ticks(5);
    wr_n_out = 1'b1;
    ticks(2);
    data_out = ~d;  // released bus must not keep the old byte
    ticks(6);
  endtask : wr
  // one read strobe; data taken while the block drives the bus
  task automatic rd(input logic sel, output logic [7:0] d, output logic oe);
    sel_out = sel;
    ticks(5);
    rd_n_out = 1'b0;
    ticks(8);
    d = rd_data_in;
    oe = oe_in;
    rd_n_out = 1'b1;
    ticks(8);
  endtask : rd
  // entry byte followed at once by its argument byte
  task automatic pair(input logic [7:0] entry, input logic [7:0] arg);
    wr(1'b0, entry);
    wr(1'b0, arg);
  endtask : pair
endmodule : lic_host_model

// ===== bench/lic_cmd_top_test.sv
// self-checking bench of the lcd command interpreter.
// assumes the host model drives the bus pins; scan and frame ticks come from here.
`timescale 1ns/100ps
module lic_cmd_top_test;
  import lic_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       line = 1'b0;
  logic       frame = 1'b0;
  logic       sel, wr_n, rd_n, disp, mir, rev, nla, ptick, pol, oe, part, ov;
  logic       osc = 1'b0;
  logic [7:0] din, dout, col, v;
  logic [5:0] sl;
  logic [3:0] page, pdiv;
  logic [2:0] duty;
  logic [4:0] ncnt;
  int         checks = 0;
  int         n_errors = 0;
  int         n;
  always #4 clk = ~clk;
  // oscillator tick every second core clock, so the divider must count ticks
  always @(negedge clk) osc <= ~osc;
  lic_host_model host (.clk_in(clk), .rd_data_in(dout), .oe_in(oe), .sel_out(sel),
    .wr_n_out(wr_n),
    .rd_n_out(rd_n), .data_out(din));
  lic_cmd_top dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CMD_DATA_SELECT_IN(sel),
    .WR_N_IN(wr_n), .RD_N_IN(rd_n), .DATA_IN(din), .OSC_TICK_IN(osc), .LINE_TICK_IN(line),
    .FRAME_START_IN(frame), .DATA_OUT(dout), .DATA_OE_OUT(oe), .DISPLAY_ON_OUT(disp),
    .START_LINE_OUT(sl), .PAGE_OUT(page), .COLUMN_OUT(col), .SEG_MIRROR_OUT(mir),
    .REVERSE_OUT(rev), .PARTIAL_OUT(part), .DUTY_OUT(duty), .NLINE_ACTIVE_OUT(nla),
    .NLINE_COUNT_OUT(ncnt), .PUMP_DIV_OUT(pdiv), .PUMP_TICK_OUT(ptick), .POLARITY_OUT(pol));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // scan line ticks, one idle cycle between them
  task automatic lines(input int k);
    repeat (k) begin
      line = 1'b1;
      @(negedge clk);
      line = 1'b0;
      @(negedge clk);
    end
  endtask : lines
  // cycles between two pump ticks, less one, bounded
  task automatic gap();
    for (int i = 0; i < 2; i++) begin
      n = 0;
      @(negedge clk);
      while (ptick !== 1'b1 && n < 200) begin
        @(negedge clk);
        n++;
      end
      if (n >= 200) begin
        n_errors++;
        end_of_test();
      end
    end
  endtask : gap
  // main sequence of bus calls and expected values
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("duty", 8'(duty), 8'h04);
    chk("pump div", 8'(pdiv), 8'h03);
    host.wr(1'b0, 8'haf);
    chk("display on", 8'(disp), 8'h01);
    host.wr(1'b0, 8'hae);
    chk("display off", 8'(disp), 8'h00);
    host.wr(1'b0, 8'h7f);
    chk("start line", 8'(sl), 8'h3f);
    host.wr(1'b0, 8'hb8);
    host.wr(1'b0, 8'hb9);
    chk("page", 8'(page), 8'h08);
    host.wr(1'b0, 8'ha1);
    host.wr(1'b0, 8'ha7);
    chk("mirror", 8'(mir), 8'h01);
    chk("reverse", 8'(rev), 8'h01);
    host.rd(1'b0, v, ov);
    chk("status", v, 8'h60);
    chk("oe during read", 8'(ov), 8'h01);
    chk("oe after read", 8'(oe), 8'h00);
    host.wr(1'b0, 8'h13);
    host.wr(1'b0, 8'h0a);
    chk("column", col, 8'h3a);
    host.wr(1'b1, 8'h5a);
    chk("column step", col, 8'h3b);
    host.wr(1'b0, 8'h13);
    host.wr(1'b0, 8'h0a);
    host.rd(1'b1, v, ov);
    chk("ram data", v, 8'h5a);
    chk("oe data read", 8'(ov), 8'h01);
    host.wr(1'b0, 8'h85);
    chk("count held", 8'(ncnt), 8'h00);
    chk("not active yet", 8'(nla), 8'h00);
    host.wr(1'b0, 8'haf);
    chk("second byte", 8'(disp), 8'h00);
    chk("count", 8'(ncnt), 8'h0f);
    chk("active", 8'(nla), 8'h01);
    frame = 1'b1;
    @(negedge clk);
    frame = 1'b0;
    repeat (3) @(negedge clk);
    v = 8'(pol);
    lines(15);
    chk("polarity held", 8'(pol), v);
    lines(1);
    chk("polarity flip", 8'(pol), ~v & 8'h01);
    host.wr(1'b0, 8'h84);
    chk("released", 8'(nla), 8'h00);
    host.pair(8'h85, 8'h01);
    host.wr(1'b0, 8'h83);
    host.wr(1'b0, 8'h30);
    chk("duty 1/9", 8'(duty), 8'h00);
    chk("cancelled", 8'(nla), 8'h00);
    chk("partial on", 8'(part), 8'h01);
    host.wr(1'b0, 8'h82);
    chk("partial off", 8'(part), 8'h00);
    chk("cancel kept", 8'(nla), 8'h00);
    host.wr(1'b0, 8'h31);
    host.wr(1'b0, 8'h35);
    chk("duty 1/17", 8'(duty), 8'h01);
    host.pair(8'h85, 8'h01);
    chk("duty idle in normal", 8'(nla), 8'h01);
    host.wr(1'b0, 8'h83);
    chk("cancel at 1/17", 8'(nla), 8'h00);
    host.pair(8'he6, 8'hf5);
    chk("div code", 8'(pdiv), 8'h05);
    gap();
    chk("pump period", 8'(n + 1), 8'h14);
    host.pair(8'he6, 8'ha0);
    chk("mirror kept", 8'(mir), 8'h01);
    host.wr(1'b0, 8'ha6);
    chk("reverse off", 8'(rev), 8'h00);
    gap();
    chk("pump undivided", 8'(n + 1), 8'h02);
    end_of_test();
  end
endmodule : lic_cmd_top_test
